// ===== design/cap_decode_defines.vh
// constants for the capability instruction classifier
`ifndef CAP_DECODE_DEFINES_VH
`define CAP_DECODE_DEFINES_VH

// register byte offsets
`define REG_CONFIG        8'h00
`define REG_INSTR         8'h04
`define REG_STATUS        8'h08
`define REG_OPINFO        8'h0C
`define REG_CAPCFG        8'h10

// configuration field positions
`define CFG_PURECAP       0
`define CFG_LEGACY        1
`define CFG_RV64          2
`define CFG_COMP          3
`define CFG_ZICBO         4
`define CFG_ATOMIC        5
`define CFG_ZABH          6
`define CFG_ZBA           7
`define CFG_ZCB           8
`define CFG_ZCMP          9
`define CFG_ZCMT          10
`define CFG_ZFH           11
`define CFG_FLT           12
`define CFG_DBL           13
`define CFG_WIDTH         14
`define CFG_RESET         14'h0001

// capability enable configuration bits
`define CAPCFG_WIDTH      3
`define CAPCFG_RESET      3'h7

// status field positions
`define ST_BUSY           0
`define ST_DONE           1
`define ST_ILLEGAL        2
`define ST_CAPMODE        3

// operation classes presented in the opinfo register
`define OP_WIDTH          6
`define OP_OTHER          6'h00
`define OP_SET_META       6'h01
`define OP_BNDS_REG       6'h02
`define OP_BNDS_IMM       6'h03
`define OP_BNDS_RUP       6'h04
`define OP_CBO_INVAL      6'h05
`define OP_CAP_EQ         6'h06
`define OP_SUBSET         6'h07
`define OP_BUILD          6'h08
`define OP_GET_PERM       6'h09
`define OP_AND_PERM       6'h0A
`define OP_INC_REG        6'h0B
`define OP_INC_IMM        6'h0C
`define OP_ADDR_SET       6'h0D
`define OP_SHADD          6'h0E
`define OP_JUMP           6'h0F
`define OP_JALR           6'h10
`define OP_JR             6'h11
`define OP_CMV            6'h12
`define OP_ALIGN_MASK     6'h13
`define OP_PREFETCH_R     6'h14
`define OP_SET_MODE       6'h15
`define OP_MODE_SW        6'h16
`define OP_LRSC_SUB       6'h17
`define OP_CBO_OTHER      6'h18

// semantic flag positions in opinfo
`define FL_CLR_TAG        8
`define FL_CLR_TAG_RND    9
`define FL_ROUND_OUT      10
`define FL_REPR_CHK       11
`define FL_TGT_CHK        12
`define FL_UNSEAL         13
`define FL_SEAL_LINK      14
`define FL_EXPAND_PERM    15
`define FL_SUBSET_CHK     16
`define FL_SET_TAG        17
`define FL_FULL_CMP       18
`define FL_AS_CLEAN       19
`define FL_NO_PERM        20
`define FL_TOGGLE_MODE    21
`define FL_CAP_MOVE       22

`endif

// ===== design/cap_isa_extension_decode.v
// capability instruction classifier with AXI4-Lite register access
// -----------------------------------------------------------------------------
// Functional notes
// - halfword/byte reserved load and conditional store ignore capability enable bits
// - legacy group support implies the whole pure-capability group
// - set metadata writes metadata and always clears destination tag
// - register/immediate bound setting rounds and clears tag when rounding needed
// - round-up bound setting rounds outward, never clears tag for rounding
// - cache block invalidate runs as a clean
// - equality compares every capability bit including metadata
// - subset test true only with matching tags and contained bounds/permissions
// - build copies second source with tag set after subset check
// - get permissions packs expanded one-bit-per-permission fields
// - permission and expands permissions before masking
// - address increment, replace and cap-mode shift-add check representability
// - jumps bounds check minimum-size target instruction
// - indirect jump-and-link unseals target, seals link; plain jump only unseals
// - compressed sp add and move act as capability ops in cap mode
// - alignment mask gives alignment for exactly representable bounds
// - read prefetch hint is always a valid instruction
// - set mode bit needs no permission in the source
// - full-size and compressed mode switch toggle execution mode
// -----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "cap_decode_defines.vh"

module cap_isa_extension_decode (
	// clock, reset, enable
	input  wire        clock_i,
	input  wire        rst_b_i,
	input  wire        clk_en_i,
	// axi4-lite write address
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [7:0]  s_axi_awaddr_i,
	// axi4-lite write data
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	// axi4-lite write response
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	output reg  [1:0]  s_axi_bresp_o,
	// axi4-lite read address
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	input  wire [7:0]  s_axi_araddr_i,
	// axi4-lite read data
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	// decode result toward execute and trap
	output reg         illegal_o,
	output reg  [22:0] op_info_o
);

	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	reg [`CFG_WIDTH-1:0]    config_ff;
	reg [`CAPCFG_WIDTH-1:0] cap_enable_bits_ff;
	reg [31:0]              instr_ff;
	reg                     cap_mode_ff;
	reg                     done_ff;
	reg                     busy_ff;
	reg [7:0]               aw_addr_ff;
	reg                     aw_got_ff;
	reg [31:0]              w_data_ff;
	reg [3:0]               w_strb_ff;
	reg                     w_got_ff;

	// byte-lane merge for a 32-bit register
	function [31:0] merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = val[i*8 +: 8];
				end
			end
		end
	endfunction

	// -------------------------------------------------------------------------
	// decode
	// -------------------------------------------------------------------------
	wire       purecap = config_ff[`CFG_PURECAP] | config_ff[`CFG_LEGACY];
	wire       legacy  = config_ff[`CFG_LEGACY];
	wire       rv64    = config_ff[`CFG_RV64];
	wire       comp    = config_ff[`CFG_COMP];
	wire [6:0] opc     = instr_ff[6:0];
	wire [2:0] f3      = instr_ff[14:12];
	wire [6:0] f7      = instr_ff[31:25];
	wire [4:0] rs2f    = instr_ff[24:20];
	wire [4:0] rdf     = instr_ff[11:7];
	wire [2:0] cf3     = instr_ff[15:13];
	wire [1:0] cq      = instr_ff[1:0];

	reg [`OP_WIDTH-1:0] op_class;
	reg                 legal;
	reg [14:0]          flags;

	always @* begin
		op_class = `OP_OTHER;
		legal    = 1'b0;
		flags    = 15'h0000;
		if (cq != 2'b11) begin
			// compressed forms need the compressed prerequisite
			if (comp && purecap) begin
				legal = 1'b1;
				if (cq == 2'b00 && cf3 == 3'b000) begin
					op_class = cap_mode_ff ? `OP_INC_IMM : `OP_OTHER;
					flags[`FL_REPR_CHK-8] = cap_mode_ff;
				end else if (cq == 2'b01 && cf3 == 3'b011 && rdf == 5'h02) begin
					op_class = cap_mode_ff ? `OP_INC_REG : `OP_OTHER;
					flags[`FL_REPR_CHK-8] = cap_mode_ff;
				end else if (cq == 2'b01 && cf3 == 3'b101) begin
					op_class = `OP_JUMP;
					flags[`FL_TGT_CHK-8] = 1'b1;
				end else if (cq == 2'b10 && cf3 == 3'b100 && instr_ff[6:2] == 5'h00) begin
					op_class = instr_ff[12] ? `OP_JALR : `OP_JR;
					flags[`FL_TGT_CHK-8] = 1'b1;
					flags[`FL_UNSEAL-8]  = 1'b1;
					flags[`FL_SEAL_LINK-8] = instr_ff[12];
				end else if (cq == 2'b10 && cf3 == 3'b100 && !instr_ff[12]) begin
					op_class = `OP_CMV;
					flags[`FL_CAP_MOVE-8] = cap_mode_ff;
				end else if (cq == 2'b01 && cf3 == 3'b100 && instr_ff[12:10] == 3'b111
					&& instr_ff[6:2] == 5'h1F) begin
					op_class = `OP_MODE_SW;
					legal    = legacy;
					flags[`FL_TOGGLE_MODE-8] = 1'b1;
				end
			end
		end else begin
			case (opc)
			7'h5B: begin
				legal = purecap;
				if (f3 == 3'b000) begin
					case (f7)
					7'h08: begin
						op_class = `OP_SET_META;
						flags[`FL_CLR_TAG-8] = 1'b1;
					end
					7'h09: begin
						op_class = `OP_BNDS_REG;
						flags[`FL_CLR_TAG_RND-8] = 1'b1;
					end
					7'h0A: begin
						op_class = `OP_BNDS_RUP;
						flags[`FL_ROUND_OUT-8] = 1'b1;
					end
					7'h0B: begin
						op_class = `OP_CAP_EQ;
						flags[`FL_FULL_CMP-8] = 1'b1;
					end
					7'h0C: begin
						op_class = `OP_SUBSET;
						flags[`FL_SUBSET_CHK-8] = 1'b1;
					end
					7'h0D: begin
						op_class = `OP_BUILD;
						flags[`FL_SUBSET_CHK-8] = 1'b1;
						flags[`FL_SET_TAG-8]    = 1'b1;
					end
					7'h0E: begin
						op_class = `OP_AND_PERM;
						flags[`FL_EXPAND_PERM-8] = 1'b1;
					end
					7'h06: begin
						op_class = `OP_INC_REG;
						flags[`FL_REPR_CHK-8] = 1'b1;
					end
					7'h0F: begin
						op_class = `OP_ADDR_SET;
						flags[`FL_REPR_CHK-8] = 1'b1;
					end
					7'h10: begin
						op_class = `OP_SET_MODE;
						legal    = legacy;
						flags[`FL_NO_PERM-8] = 1'b1;
					end
					7'h11: begin
						op_class = `OP_MODE_SW;
						legal    = legacy;
						flags[`FL_TOGGLE_MODE-8] = 1'b1;
					end
					7'h12: begin
						case (rs2f)
						5'h00: begin
							op_class = `OP_GET_PERM;
							flags[`FL_EXPAND_PERM-8] = 1'b1;
						end
						5'h01: begin
							op_class = `OP_ALIGN_MASK;
							flags[`FL_ROUND_OUT-8] = 1'b1;
						end
						5'h02: op_class = `OP_CMV;
						default: legal = 1'b0;
						endcase
					end
					default: legal = 1'b0;
					endcase
				end else if (f3 == 3'b001) begin
					op_class = `OP_BNDS_IMM;
					flags[`FL_CLR_TAG_RND-8] = 1'b1;
				end else if (f3 == 3'b010) begin
					op_class = `OP_INC_IMM;
					flags[`FL_REPR_CHK-8] = 1'b1;
				end else begin
					legal = 1'b0;
				end
			end
			7'h6F: begin
				legal    = purecap;
				op_class = `OP_JUMP;
				flags[`FL_TGT_CHK-8] = 1'b1;
			end
			7'h67: begin
				legal    = purecap;
				op_class = (rdf == 5'h00) ? `OP_JR : `OP_JALR;
				flags[`FL_TGT_CHK-8]   = 1'b1;
				flags[`FL_UNSEAL-8]    = 1'b1;
				flags[`FL_SEAL_LINK-8] = (rdf != 5'h00);
			end
			7'h2F: begin
				// sub-word reserved accesses depend only on their own group
				if (f3 == 3'b000 || f3 == 3'b001) begin
					op_class = `OP_LRSC_SUB;
					legal    = config_ff[`CFG_ZABH];
				end else begin
					legal = config_ff[`CFG_ATOMIC] && (f3 != 3'b011 || rv64);
				end
			end
			7'h0F: begin
				if (f3 == 3'b010) begin
					legal    = config_ff[`CFG_ZICBO];
					op_class = (rs2f == 5'h00) ? `OP_CBO_INVAL : `OP_CBO_OTHER;
					flags[`FL_AS_CLEAN-8] = (rs2f == 5'h00);
				end else begin
					legal = 1'b1;
				end
			end
			7'h13: begin
				legal = 1'b1;
				if (f3 == 3'b110 && rdf == 5'h00 && rs2f == 5'h01) begin
					op_class = `OP_PREFETCH_R;
				end
			end
			7'h33, 7'h3B: begin
				legal = 1'b1;
				if (f7 == 7'h10 || (opc == 7'h3B && f7 == 7'h04)) begin
					legal    = config_ff[`CFG_ZBA] && (opc == 7'h33 || rv64);
					op_class = `OP_SHADD;
					flags[`FL_REPR_CHK-8] = cap_mode_ff;
				end
			end
			7'h07, 7'h27: begin
				legal = (f3 == 3'b001) ? config_ff[`CFG_ZFH] :
					(f3 == 3'b010) ? config_ff[`CFG_FLT] :
					(f3 == 3'b011) ? config_ff[`CFG_DBL] : 1'b0;
			end
			7'h03, 7'h23, 7'h17, 7'h37, 7'h1B, 7'h63, 7'h73: legal = 1'b1;
			default: legal = 1'b0;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// bus slave and decode pipeline
	// -------------------------------------------------------------------------
	wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
	wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
	wire wr_go   = aw_got_ff & w_got_ff & ~s_axi_bvalid_o;
	wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
	wire [31:0] cfg_merged = merge({18'h00000, config_ff}, w_data_ff, w_strb_ff);

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			config_ff          <= `CFG_RESET;
			cap_enable_bits_ff <= `CAPCFG_RESET;
			instr_ff           <= 32'h00000000;
			cap_mode_ff        <= 1'b1;
			done_ff            <= 1'b0;
			busy_ff            <= 1'b0;
			aw_addr_ff         <= 8'h00;
			aw_got_ff          <= 1'b0;
			w_data_ff          <= 32'h00000000;
			w_strb_ff          <= 4'h0;
			w_got_ff           <= 1'b0;
			s_axi_awready_o    <= 1'b0;
			s_axi_wready_o     <= 1'b0;
			s_axi_bvalid_o     <= 1'b0;
			s_axi_bresp_o      <= 2'b00;
			s_axi_arready_o    <= 1'b0;
			s_axi_rvalid_o     <= 1'b0;
			s_axi_rdata_o      <= 32'h00000000;
			s_axi_rresp_o      <= 2'b00;
			illegal_o          <= 1'b0;
			op_info_o          <= 23'h000000;
		end else if (clk_en_i) begin
			s_axi_awready_o <= ~aw_got_ff & ~aw_take;
			s_axi_wready_o  <= ~w_got_ff & ~w_take;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr_i;
				aw_got_ff  <= 1'b1;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata_i;
				w_strb_ff <= s_axi_wstrb_i;
				w_got_ff  <= 1'b1;
			end
			// one-cycle decode latency after an instruction write
			busy_ff <= 1'b0;
			if (busy_ff) begin
				done_ff   <= 1'b1;
				illegal_o <= ~legal;
				op_info_o <= {flags, 2'b00, op_class};
				if (legal && flags[`FL_TOGGLE_MODE-8]) begin
					cap_mode_ff <= ~cap_mode_ff;
				end
			end
			if (wr_go) begin
				aw_got_ff      <= 1'b0;
				w_got_ff       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= 2'b00;
				case (aw_addr_ff)
				`REG_CONFIG: config_ff <= cfg_merged[`CFG_WIDTH-1:0];
				`REG_INSTR: begin
					instr_ff <= merge(instr_ff, w_data_ff, w_strb_ff);
					busy_ff  <= 1'b1;
					done_ff  <= 1'b0;
				end
				`REG_CAPCFG: cap_enable_bits_ff <= w_strb_ff[0] ?
					w_data_ff[`CAPCFG_WIDTH-1:0] : cap_enable_bits_ff;
				`REG_STATUS, `REG_OPINFO: s_axi_bresp_o <= 2'b00;
				default: s_axi_bresp_o <= 2'b10;
				endcase
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
			s_axi_arready_o <= ~s_axi_rvalid_o & ~ar_take;
			if (ar_take) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o  <= 2'b00;
				case (s_axi_araddr_i)
				`REG_CONFIG: s_axi_rdata_o <= {18'h00000, config_ff};
				`REG_INSTR:  s_axi_rdata_o <= instr_ff;
				`REG_STATUS: s_axi_rdata_o <= {28'h0000000, cap_mode_ff, illegal_o,
					done_ff, busy_ff};
				`REG_OPINFO: s_axi_rdata_o <= {9'h000, op_info_o};
				`REG_CAPCFG: s_axi_rdata_o <= {29'h00000000, cap_enable_bits_ff};
				default: begin
					s_axi_rdata_o <= 32'h00000000;
					s_axi_rresp_o <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

endmodule // cap_isa_extension_decode

// ===== bench/exec_sink.sv
// far side model: execute and trap stage counting trap requests
`timescale 1ns/1ps
module exec_sink (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_b_i,
	// decode result
	input  wire        illegal_i,
	output reg  [15:0] trap_cnt_o
);
	reg prev_ff;
	// a level result is held until the next decode, so only a rising edge is a new trap
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_ff <= 1'b0;
			trap_cnt_o <= 16'h0000;
		end else begin
			prev_ff <= illegal_i;
			if (illegal_i && !prev_ff)
				trap_cnt_o <= trap_cnt_o + 16'h0001;
		end
	end
endmodule // exec_sink

// ===== bench/cap_decode_sva.sv
// assertion checker for the capability instruction classifier
`timescale 1ns/1ps
`include "cap_decode_defines.vh"
module cap_decode_sva (
	// clock and reset
	input wire        clock_i,
	input wire        rst_b_i,
	// register bus
	input wire        s_axi_awvalid_i,
	input wire        s_axi_awready_o,
	input wire        s_axi_wvalid_i,
	input wire        s_axi_wready_o,
	input wire        s_axi_bvalid_o,
	input wire        s_axi_bready_i,
	input wire [1:0]  s_axi_bresp_o,
	input wire        s_axi_arvalid_i,
	input wire        s_axi_arready_o,
	input wire        s_axi_rvalid_o,
	input wire        s_axi_rready_i,
	input wire [31:0] s_axi_rdata_o,
	// decode result
	input wire        illegal_o,
	input wire [22:0] op_info_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	wire [5:0] cls = op_info_o[5:0];
	a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
	a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while data pending");
	a_write_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
	a_read_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
	a_pad_zero: assert property (op_info_o[7:6] == 2'h0) else $error("class padding set");
	a_round_excl: assert property (!(op_info_o[`FL_CLR_TAG_RND] && op_info_o[`FL_ROUND_OUT]))
		else $error("round-up also clears tag");
	a_inval_clean: assert property (!illegal_o && cls == `OP_CBO_INVAL |->
		op_info_o[`FL_AS_CLEAN]) else $error("invalidate not run as clean");
	a_jalr_seal: assert property (!illegal_o && cls == `OP_JALR |-> op_info_o[`FL_TGT_CHK]
		&& op_info_o[`FL_UNSEAL] && op_info_o[`FL_SEAL_LINK]) else $error("jalr flags wrong");
	a_link_unseal: assert property (op_info_o[`FL_SEAL_LINK] |-> op_info_o[`FL_UNSEAL])
		else $error("link sealed without unseal");
	a_build_subset: assert property (op_info_o[`FL_SET_TAG] |-> op_info_o[`FL_SUBSET_CHK])
		else $error("tag set without subset check");
	a_meta_clr: assert property (!illegal_o && cls == `OP_SET_META |-> op_info_o[`FL_CLR_TAG])
		else $error("set metadata keeps tag");
	c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
	c_illegal: cover property (illegal_o);
	c_inval: cover property (!illegal_o && cls == `OP_CBO_INVAL);
endmodule // cap_decode_sva
bind cap_isa_extension_decode cap_decode_sva cap_decode_sva_inst (.clock_i, .rst_b_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .s_axi_rdata_o, .illegal_o, .op_info_o);

// ===== bench/tb.sv
// self-checking bench for the capability instruction classifier
`timescale 1ns/1ps
`include "cap_decode_defines.vh"
module tb;
	reg         clock_i, rst_b_i, clk_en, awvalid, wvalid, bready, arvalid, rready;
	reg  [7:0]  awaddr, araddr;
	reg  [31:0] wdata, seed, rd_v, cfg;
	reg  [3:0]  wstrb;
	reg  [1:0]  resp;
	wire        awready, wready, bvalid, arready, rvalid, illegal;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [22:0] op_info;
	wire [15:0] trap_cnt;
	integer     error_cnt, num_checks, i, k;
	reg  [31:0] tmpl [0:24], fmsk [0:24], need [0:24], cls [0:24], flg [0:24];
	reg         mode;

	cap_isa_extension_decode cap_isa_extension_decode_inst (.clock_i(clock_i),
		.rst_b_i(rst_b_i), .clk_en_i(clk_en), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .illegal_o(illegal), .op_info_o(op_info));
	exec_sink exec_sink_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .illegal_i(illegal),
		.trap_cnt_o(trap_cnt));

	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction

	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
				error_cnt = error_cnt + 1;
			end
		end
	endtask

	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		integer t;
		begin
			@(posedge clock_i);
			awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
			for (t = 0; t < 60; t = t + 1) begin
				@(posedge clock_i);
				if (awvalid && awready) awvalid <= 1'b0;
				if (wvalid && wready) wvalid <= 1'b0;
				if (bvalid && bready) begin
					resp = bresp; bready <= 1'b0; t = 99;
				end
			end
		end
	endtask

	task rd(input [7:0] a);
		integer t;
		begin
			@(posedge clock_i);
			arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
			for (t = 0; t < 60; t = t + 1) begin
				@(posedge clock_i);
				if (arvalid && arready) arvalid <= 1'b0;
				if (rvalid && rready) begin
					rd_v = rdata; resp = rresp; rready <= 1'b0; t = 99;
				end
			end
		end
	endtask

	task ent(input integer e, input [31:0] t, m, n, c, f);
		begin
			tmpl[e] = t;
			fmsk[e] = m;
			need[e] = n;
			cls[e] = c;
			flg[e] = f;
		end
	endtask

	// legacy support carries the whole pure-capability group with it
	task dec(input [31:0] ins, input integer e);
		reg leg;
		begin
			leg = (need[e] == 15) || (((cfg | {31'h0, cfg[1]}) >> need[e]) & 1);
			// a legal mode switch flips the execution mode that status shows
			if (leg && cls[e] == `OP_MODE_SW)
				mode = !mode;
			wr(`REG_INSTR, ins, 4'hF);
			rd(`REG_STATUS);
			chk("status", {28'h0, mode, !leg, 2'h2}, rd_v[3:0]);
			chk("illegal", {31'h0, !leg}, {31'h0, illegal});
			rd(`REG_OPINFO);
			chk("opinfo", {9'h0, op_info}, rd_v);
			if (leg) begin
				chk("class", cls[e], {26'h0, op_info[5:0]});
				chk("flags", flg[e], {9'h0, op_info} & flg[e]);
			end
		end
	endtask

	task print_verdict;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	initial begin
		repeat (30000) @(posedge clock_i);
		error_cnt = error_cnt + 1;
		print_verdict;
	end

	initial begin
		rst_b_i = 1'b0; clk_en = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
		wstrb = 4'h0; seed = 32'h7510; error_cnt = 0; num_checks = 0; cfg = 32'h1;
		mode = 1'b1;
		// sub-word reserved pair, cache ops, prefetch, shift-add, jumps
		tmpl[0] = 32'h1000102F; fmsk[0] = 32'h000F8F80; need[0] = 6; cls[0] = `OP_LRSC_SUB; flg[0] = 0;
		tmpl[1] = 32'h1800002F; fmsk[1] = 32'h01FF8F80; need[1] = 6; cls[1] = `OP_LRSC_SUB; flg[1] = 0;
		tmpl[2] = 32'h0000200F; fmsk[2] = 32'h000F8000; need[2] = 4; cls[2] = `OP_CBO_INVAL;
		flg[2] = 1 << `FL_AS_CLEAN;
		tmpl[3] = 32'h0010200F; fmsk[3] = 32'h000F8000; need[3] = 4; cls[3] = `OP_CBO_OTHER; flg[3] = 0;
		tmpl[4] = 32'h00106013; fmsk[4] = 32'h000F8000; need[4] = 15; cls[4] = `OP_PREFETCH_R; flg[4] = 0;
		tmpl[5] = 32'h20002033; fmsk[5] = 32'h01FF8F80; need[5] = 7; cls[5] = `OP_SHADD;
		flg[5] = 1 << `FL_REPR_CHK;
		tmpl[6] = 32'h0000006F; fmsk[6] = 32'h00000F80; need[6] = 0; cls[6] = `OP_JUMP;
		flg[6] = 1 << `FL_TGT_CHK;
		tmpl[7] = 32'h000000E7; fmsk[7] = 32'h000F8000; need[7] = 0; cls[7] = `OP_JALR;
		flg[7] = (1 << `FL_TGT_CHK) | (1 << `FL_UNSEAL) | (1 << `FL_SEAL_LINK);
		// capability operations, compressed move, both mode switches
		// compressed forms only appear legal where legacy comes with compressed
		ent(8, 32'h1000005B, 32'h01FF8F80, 0, `OP_SET_META, 1 << `FL_CLR_TAG);
		ent(9, 32'h1200005B, 32'h01FF8F80, 0, `OP_BNDS_REG, 1 << `FL_CLR_TAG_RND);
		ent(10, 32'h1400005B, 32'h01FF8F80, 0, `OP_BNDS_RUP, 1 << `FL_ROUND_OUT);
		ent(11, 32'h1600005B, 32'h01FF8F80, 0, `OP_CAP_EQ, 1 << `FL_FULL_CMP);
		ent(12, 32'h1800005B, 32'h01FF8F80, 0, `OP_SUBSET, 1 << `FL_SUBSET_CHK);
		ent(13, 32'h1A00005B, 32'h01FF8F80, 0, `OP_BUILD, 3 << `FL_SUBSET_CHK);
		ent(14, 32'h1C00005B, 32'h01FF8F80, 0, `OP_AND_PERM, 1 << `FL_EXPAND_PERM);
		ent(15, 32'h0C00005B, 32'h01FF8F80, 0, `OP_INC_REG, 1 << `FL_REPR_CHK);
		ent(16, 32'h1E00005B, 32'h01FF8F80, 0, `OP_ADDR_SET, 1 << `FL_REPR_CHK);
		ent(17, 32'h2400005B, 32'h000F8F80, 0, `OP_GET_PERM, 1 << `FL_EXPAND_PERM);
		ent(18, 32'h2410005B, 32'h000F8F80, 0, `OP_ALIGN_MASK, 1 << `FL_ROUND_OUT);
		ent(19, 32'h2000005B, 32'h01FF8F80, 1, `OP_SET_MODE, 1 << `FL_NO_PERM);
		ent(20, 32'h0000105B, 32'hFFFF8F80, 0, `OP_BNDS_IMM, 1 << `FL_CLR_TAG_RND);
		ent(21, 32'h0000205B, 32'hFFFF8F80, 0, `OP_INC_IMM, 1 << `FL_REPR_CHK);
		ent(22, 32'h00008006, 32'h00000F80, 3, `OP_CMV, 1 << `FL_CAP_MOVE);
		ent(23, 32'h2200005B, 32'h01FF8F80, 1, `OP_MODE_SW, 1 << `FL_TOGGLE_MODE);
		ent(24, 32'h00009C7D, 32'h00000380, 1, `OP_MODE_SW, 1 << `FL_TOGGLE_MODE);
		repeat (16) @(posedge clock_i);
		rst_b_i <= 1'b1;
		rd(`REG_CONFIG); chk("config reset", 32'h1, rd_v);
		rd(`REG_CAPCFG); chk("capcfg reset", 32'h7, rd_v);
		rd(`REG_STATUS); chk("status reset", 32'h8, rd_v);
		rd(8'h14); chk("unmapped rresp", 32'h2, {30'h0, resp}); chk("unmapped rdata", 0, rd_v);
		wr(8'h14, 32'h0, 4'hF); chk("unmapped bresp", 32'h2, {30'h0, resp});
		seed = xs(seed);
		wr(`REG_STATUS, seed, 4'hF); chk("status wr resp", 0, {30'h0, resp});
		wr(`REG_OPINFO, seed, 4'hF); rd(`REG_STATUS); chk("status ro", 32'h8, rd_v);
		rd(`REG_OPINFO); chk("opinfo ro", 0, rd_v);
		wr(`REG_CONFIG, 32'hFFFF, 4'h2); rd(`REG_CONFIG); chk("config lane", 32'h3F01, rd_v);
		wr(`REG_CAPCFG, 0, 4'hE); rd(`REG_CAPCFG); chk("capcfg lane", 32'h7, rd_v);
		wr(`REG_CAPCFG, 0, 4'h1); rd(`REG_CAPCFG); chk("capcfg write", 32'h0, rd_v);
		for (k = 0; k < 4; k = k + 1) begin
			cfg = (k == 0) ? 32'h1 : (k == 3) ? 32'hA : 32'h01F1;
			wr(`REG_CONFIG, cfg, 4'hF);
			wr(`REG_CAPCFG, (k == 1) ? 32'h7 : 32'h0, 4'h1);
			for (i = 0; i < 25; i = i + 1) begin
				seed = xs(seed);
				dec(tmpl[i] | (seed & fmsk[i]), i);
			end
		end
		chk("trap seen", 32'h1, {31'h0, trap_cnt != 16'h0000});
		print_verdict;
	end
endmodule // tb
